//--- disk_regs_pkg.sv
// Constants and types shared by the disk controller program register bank.
// Assumes bit n of a 12-bit word is vector index n of word_t.
package disk_regs_pkg;

  localparam int NUM_PORTS = 4;
  localparam int WORD_W = 12;

  typedef logic [WORD_W-1:0] word_t;
  typedef logic [1:0] port_t;
  typedef logic [1:0] ecode_t;

  // Transfer control register fields
  localparam int CTL_EXT_LSB = 0;
  localparam int CTL_EXT_W = 3;
  localparam int CTL_UNUSED_A = 3;
  localparam int CTL_UNUSED_B = 4;
  localparam int CTL_IE = 5;
  localparam int CTL_FE = 6;
  localparam int CTL_SEL_LSB = 7;
  localparam int CTL_RD = 9;
  localparam int CTL_BUSY = 10;
  localparam int CTL_DONE = 11;

  // Transfer error status register fields
  localparam int STS_ERR = 0;
  localparam int STS_SEL_LSB = 1;
  localparam int STS_ADR_LSB = 3;
  localparam int STS_DAT_LSB = 5;
  localparam int STS_UNUSED_LSB = 7;
  localparam int STS_BUSY = 10;
  localparam int STS_DONE = 11;

  // Per-port seek status field layout
  localparam int SK_FLD_W = 3;
  localparam int SK_HW_ERR = 0;
  localparam int SK_BUSY_ERR = 1;
  localparam int SK_NOT_RDY = 2;
  localparam logic [SK_FLD_W-1:0] SK_ABSENT = 3'h7;

  // Error group selector carried with an error event
  localparam logic [1:0] GRP_SEL = 2'h0;
  localparam logic [1:0] GRP_ADR = 2'h1;
  localparam logic [1:0] GRP_DAT = 2'h2;

  localparam ecode_t ECODE_NONE = 2'h0;
  localparam ecode_t SEL_FORMAT = 2'h1;
  localparam ecode_t SEL_SELECT = 2'h2;
  localparam ecode_t SEL_TIMING = 2'h3;
  localparam ecode_t ADR_INTERLOCK = 2'h1;
  localparam ecode_t ADR_VERIFY = 2'h2;
  localparam ecode_t ADR_SEEK_INC = 2'h3;
  localparam ecode_t DAT_LOCKOUT = 2'h1;
  localparam ecode_t DAT_WCHECK = 2'h2;
  localparam ecode_t DAT_CHECKSUM = 2'h3;

  localparam word_t WORD_ZERO = 12'h000;

  typedef enum logic [1:0] {
    REG_CONTROL = 2'h0,
    REG_STATUS = 2'h1,
    REG_SEEK_STATUS = 2'h2,
    REG_NONE = 2'h3
  } reg_sel_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    reg_sel_e sel;
    word_t wdata;
  } pio_req_s;

  typedef struct packed {
    logic valid;
    logic [1:0] group;
    ecode_t code;
  } xfer_err_s;

endpackage

//--- port_seek_status.sv
// One disk port's three-bit seek status cell: result bits and live readiness.
// Assumes seek requests and drive status are synchronous one-cycle pulses/levels.
`timescale 1ns/10ps
`default_nettype none
module port_seek_status
  import disk_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Drive state
  input wire logic present_i,
  input wire logic ready_i,
  input wire logic moving_i,
  input wire logic transferring_i,
  // Seek events
  input wire logic seek_req_i,
  input wire logic seek_done_i,
  input wire logic seek_hw_err_i,
  input wire logic seek_incomplete_i,
  // Results
  output logic seek_go_o,
  output logic restore_o,
  output logic [SK_FLD_W-1:0] field_o
);
  logic hw_err_r;
  logic busy_err_r;
  logic restore_r;
  logic accept;
  logic reject;
  logic fail;

  assign accept = seek_req_i && present_i && ready_i && !moving_i && !transferring_i;
  assign reject = seek_req_i && !accept;
  assign fail = seek_done_i && (seek_hw_err_i || seek_incomplete_i);
  assign seek_go_o = accept && ce_i;
  assign restore_o = restore_r;

  // Completion result wins over the clear of a newly started seek
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hw_err_r <= 1'b0;
    end else if (ce_i) begin
      if (fail) begin
        hw_err_r <= 1'b1;
      end else if (accept) begin
        hw_err_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_err_r <= 1'b0;
    end else if (ce_i) begin
      if (reject) begin
        busy_err_r <= 1'b1;
      end else if (accept) begin
        busy_err_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      restore_r <= 1'b0;
    end else if (ce_i) begin
      restore_r <= seek_done_i && seek_incomplete_i;
    end
  end

  // Absent drive forces all ones; readiness bit is live, not stored
  assign field_o = !present_i ? SK_ABSENT
                              : {moving_i || !ready_i, busy_err_r, hw_err_r};

  a_seek_discard: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && reject) |-> !seek_go_o ##1 busy_err_r) else $error("rejected seek not discarded");

endmodule
`default_nettype wire

//--- disk_ctrl_regs.sv
// Program-visible register bank of a four-port disk controller: transfer
// control, transfer error status and per-port seek status.
// Assumes the host reaches it by programmed I/O strobes synchronous to CLK_I,
// and the transfer engine and drives report events as one-cycle pulses.
// Operation
// - Control bits 0-2 hold the high DMA address extension bits.
// - Control bits 3,4 and status bits 7-9 always read zero.
// - With interrupt enable set, done becoming set requests an interrupt.
// - Format enable permits formatting; formatting refused while clear.
// - Control bits 7,8 select the port for a data transfer.
// - Control bit 9 set while reading disk, clear while writing.
// - Control bit 10 set while a data transfer is busy.
// - Done sets at transfer end, or seek end with no transfer active.
// - Status bit 0 flags that an error occurred.
// - Status bits 1,2 report format, select or host timing error.
// - Status bits 3,4 report interlock, verification or seek-incomplete error.
// - Seek-incomplete is reported and triggers an automatic restore of that disk.
// - Status bits 5,6 report write lockout, write check or checksum error.
// - On moving-head disks the format switch override suppresses lockout errors.
// - Status bits 10,11 are the same busy and done storage as control.
// - Seek status holds four 3-bit fields, port 3 lowest, port 0 highest.
// - Seek status is read-only; a started seek clears its result bits.
// - A port with no disk reads its seek field as all ones.
// - First field bit flags a hardware seek error.
// - Middle field bit flags a busy error; the seek is discarded.
// - Last field bit reads one while moving or not ready.
// - Control and status read/write; seek status read only.
// - Any sensed error stops the operation and leaves the cause recorded.
`timescale 1ns/10ps
`default_nettype none
module disk_ctrl_regs
  import disk_regs_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // Programmed I/O
  input wire disk_regs_pkg::pio_req_s PIO_REQ_I,
  output disk_regs_pkg::word_t PIO_RDATA_O,
  // Transfer engine
  input wire logic XFER_START_I,
  input wire logic XFER_READ_I,
  input wire logic XFER_END_I,
  input wire disk_regs_pkg::xfer_err_s XFER_ERR_I,
  input wire logic FMT_REQ_I,
  input wire logic WP_HIT_I,
  input wire logic FMT_SWITCH_I,
  output logic FMT_GRANT_O,
  output logic ABORT_O,
  output logic [CTL_EXT_W-1:0] DMA_EXT_O,
  output disk_regs_pkg::port_t UNIT_SEL_O,
  output logic INT_REQ_O,
  // Drive ports
  input wire logic [NUM_PORTS-1:0] DISK_PRESENT_I,
  input wire logic [NUM_PORTS-1:0] DRIVE_READY_I,
  input wire logic [NUM_PORTS-1:0] FIXED_HEAD_I,
  input wire logic [NUM_PORTS-1:0] HEAD_MOVING_I,
  input wire logic SEEK_REQ_I,
  input wire disk_regs_pkg::port_t SEEK_PORT_I,
  input wire logic [NUM_PORTS-1:0] SEEK_DONE_I,
  input wire logic [NUM_PORTS-1:0] SEEK_HW_ERR_I,
  input wire logic [NUM_PORTS-1:0] SEEK_INCOMPLETE_I,
  output logic [NUM_PORTS-1:0] SEEK_GO_O,
  output logic [NUM_PORTS-1:0] RESTORE_O
);
  import disk_regs_pkg::*;

  // Lowest bit of a port's seek field; port 0 sits at the top of the word
  function automatic int seek_lsb(input int port);
    seek_lsb = (NUM_PORTS - 1 - port) * SK_FLD_W;
  endfunction

  function automatic logic is_port(input port_t sel, input int port);
    is_port = (sel == port_t'(port));
  endfunction

  xfer_state_e state_r;
  logic [CTL_EXT_W-1:0] ext_r;
  logic ie_r;
  logic fe_r;
  port_t sel_r;
  logic rd_dir_r;
  logic done_r;
  ecode_t sel_code_r;
  ecode_t adr_code_r;
  ecode_t dat_code_r;
  word_t rdata_r;
  logic grant_r;
  logic abort_r;
  logic [NUM_PORTS-1:0] xfer_restore_r;
  word_t seek_word;
  word_t ctl_word;
  word_t sts_word;
  logic busy;
  logic err_flag;
  logic start_bad;
  logic fmt_bad;
  logic wp_err;
  logic err_evt;
  logic seek_end;
  logic ctl_wr;
  logic sts_wr;
  logic [NUM_PORTS-1:0] port_restore;

  assign busy = (state_r == ST_XFER);
  assign ctl_wr = PIO_REQ_I.wr && (PIO_REQ_I.sel == REG_CONTROL);
  assign sts_wr = PIO_REQ_I.wr && (PIO_REQ_I.sel == REG_STATUS);
  assign start_bad = XFER_START_I && !(DISK_PRESENT_I[sel_r] && DRIVE_READY_I[sel_r]);
  assign fmt_bad = FMT_REQ_I && (!fe_r || FIXED_HEAD_I[sel_r]);
  assign wp_err = WP_HIT_I && !(!FIXED_HEAD_I[sel_r] && FMT_SWITCH_I);
  assign err_evt = XFER_ERR_I.valid || start_bad || fmt_bad || wp_err;
  assign seek_end = |SEEK_DONE_I;

  // Transfer sequencing; any error ends the operation at once
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      state_r <= ST_IDLE;
    end else if (CE_I) begin
      unique case (state_r)
        ST_IDLE: begin
          if (XFER_START_I && !start_bad) begin
            state_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (XFER_END_I || err_evt) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Host-owned control fields
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ext_r <= '0;
      ie_r <= 1'b0;
      fe_r <= 1'b0;
      sel_r <= '0;
    end else if (CE_I && ctl_wr) begin
      ext_r <= PIO_REQ_I.wdata[CTL_EXT_LSB +: CTL_EXT_W];
      ie_r <= PIO_REQ_I.wdata[CTL_IE];
      fe_r <= PIO_REQ_I.wdata[CTL_FE];
      sel_r <= PIO_REQ_I.wdata[CTL_SEL_LSB +: 2];
    end
  end

  // Direction is hardware-owned; host writes to it are ignored
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rd_dir_r <= 1'b0;
    end else if (CE_I && XFER_START_I && !busy) begin
      rd_dir_r <= XFER_READ_I;
    end
  end

  // Done: hardware set wins over a host write of zero in the same cycle
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      done_r <= 1'b0;
    end else if (CE_I) begin
      if ((busy && (XFER_END_I || err_evt)) || start_bad || (seek_end && !busy)) begin
        done_r <= 1'b1;
      end else if (ctl_wr) begin
        done_r <= PIO_REQ_I.wdata[CTL_DONE];
      end else if (XFER_START_I) begin
        done_r <= 1'b0;
      end
    end
  end

  // Error codes: a sensed error overrides a host write to its group
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sel_code_r <= ECODE_NONE;
    end else if (CE_I) begin
      if (fmt_bad) begin
        sel_code_r <= SEL_FORMAT;
      end else if (start_bad) begin
        sel_code_r <= SEL_SELECT;
      end else if (XFER_ERR_I.valid && XFER_ERR_I.group == GRP_SEL) begin
        sel_code_r <= XFER_ERR_I.code;
      end else if (sts_wr) begin
        sel_code_r <= PIO_REQ_I.wdata[STS_SEL_LSB +: 2];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      adr_code_r <= ECODE_NONE;
    end else if (CE_I) begin
      if (XFER_ERR_I.valid && XFER_ERR_I.group == GRP_ADR) begin
        adr_code_r <= XFER_ERR_I.code;
      end else if (sts_wr) begin
        adr_code_r <= PIO_REQ_I.wdata[STS_ADR_LSB +: 2];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      dat_code_r <= ECODE_NONE;
    end else if (CE_I) begin
      if (wp_err) begin
        dat_code_r <= DAT_LOCKOUT;
      end else if (XFER_ERR_I.valid && XFER_ERR_I.group == GRP_DAT) begin
        dat_code_r <= XFER_ERR_I.code;
      end else if (sts_wr) begin
        dat_code_r <= PIO_REQ_I.wdata[STS_DAT_LSB +: 2];
      end
    end
  end

  // Engine strobes
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      grant_r <= 1'b0;
      abort_r <= 1'b0;
      xfer_restore_r <= '0;
    end else if (CE_I) begin
      grant_r <= FMT_REQ_I && !fmt_bad;
      abort_r <= busy && err_evt;
      for (int p = 0; p < NUM_PORTS; p++) begin
        xfer_restore_r[p] <= XFER_ERR_I.valid && XFER_ERR_I.group == GRP_ADR
                             && XFER_ERR_I.code == ADR_SEEK_INC && is_port(sel_r, p);
      end
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      port_seek_status u_seek (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .ce_i(CE_I),
        .present_i(DISK_PRESENT_I[gp]),
        .ready_i(DRIVE_READY_I[gp]),
        .moving_i(HEAD_MOVING_I[gp]),
        .transferring_i(busy && is_port(sel_r, gp)),
        .seek_req_i(SEEK_REQ_I && is_port(SEEK_PORT_I, gp)),
        .seek_done_i(SEEK_DONE_I[gp]),
        .seek_hw_err_i(SEEK_HW_ERR_I[gp]),
        .seek_incomplete_i(SEEK_INCOMPLETE_I[gp]),
        .seek_go_o(SEEK_GO_O[gp]),
        .restore_o(port_restore[gp]),
        .field_o(seek_word[seek_lsb(gp) +: SK_FLD_W])
      );
    end
  endgenerate

  assign err_flag = (sel_code_r != ECODE_NONE) || (adr_code_r != ECODE_NONE)
                    || (dat_code_r != ECODE_NONE);
  assign ctl_word = {done_r, busy, rd_dir_r, sel_r, fe_r, ie_r, 2'b00, ext_r};
  assign sts_word = {done_r, busy, 3'b000, dat_code_r, adr_code_r, sel_code_r, err_flag};

  // Read data is captured on the read strobe; seek status ignores writes
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rdata_r <= WORD_ZERO;
    end else if (CE_I && PIO_REQ_I.rd) begin
      unique case (PIO_REQ_I.sel)
        REG_CONTROL: rdata_r <= ctl_word;
        REG_STATUS: rdata_r <= sts_word;
        REG_SEEK_STATUS: rdata_r <= seek_word;
        REG_NONE: rdata_r <= WORD_ZERO;
      endcase
    end
  end

  assign PIO_RDATA_O = rdata_r;
  assign FMT_GRANT_O = grant_r;
  assign ABORT_O = abort_r;
  assign DMA_EXT_O = ext_r;
  assign UNIT_SEL_O = sel_r;
  assign RESTORE_O = port_restore | xfer_restore_r;
  // Level request: the host sees it from the edge where done sets
  assign INT_REQ_O = ie_r && done_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_start;
    CE_I && XFER_START_I && !start_bad && !busy;
  endsequence

  sequence s_end;
    CE_I && busy && XFER_END_I;
  endsequence

  // Checked from the transfer end so a broken done path is caught too
  a_irq_on_done: assert property (CE_I && busy && XFER_END_I && ie_r && !ctl_wr |=> INT_REQ_O)
    else $error("done set without interrupt request");
  a_ctl_unused: assert property (CE_I && PIO_REQ_I.rd && PIO_REQ_I.sel == REG_CONTROL
    |=> PIO_RDATA_O[CTL_UNUSED_B:CTL_UNUSED_A] == 2'b00) else $error("control unused bits nonzero");
  a_format_gate: assert property (CE_I && FMT_REQ_I && !fe_r
    |=> !FMT_GRANT_O && sel_code_r == SEL_FORMAT) else $error("format allowed while disabled");
  a_xfer_cycle: assert property (s_start ##1 s_end |=> !busy && done_r)
    else $error("transfer did not end with done");
  a_busy_start: assert property (s_start |=> busy && rd_dir_r == $past(XFER_READ_I))
    else $error("busy or direction wrong after start");
  a_err_flag: assert property (CE_I && PIO_REQ_I.rd && PIO_REQ_I.sel == REG_STATUS
    |=> PIO_RDATA_O[STS_ERR] == $past(err_flag) && PIO_RDATA_O[STS_DONE] == $past(done_r))
    else $error("status flag or done mismatch");
  a_wp_override: assert property (CE_I && WP_HIT_I && FMT_SWITCH_I && !FIXED_HEAD_I[sel_r]
    && !XFER_ERR_I.valid && !sts_wr |=> dat_code_r == $past(dat_code_r)) else $error("lockout not suppressed");
  a_stop_on_err: assert property (CE_I && busy && err_evt |=> !busy && ABORT_O && done_r)
    else $error("error did not stop transfer");
  // Port 3 holds the lowest field of the seek word
  a_seek_absent: assert property (CE_I && PIO_REQ_I.rd && PIO_REQ_I.sel == REG_SEEK_STATUS
    && !DISK_PRESENT_I[3] |=> PIO_RDATA_O[SK_FLD_W-1:0] == SK_ABSENT) else $error("absent port not all ones");
  a_restore_inc: assert property (CE_I && SEEK_DONE_I[2] && SEEK_INCOMPLETE_I[2] |=> RESTORE_O[2])
    else $error("no restore after seek incomplete");

endmodule
`default_nettype wire

//--- host_pio_model.sv
// Host processor model: issues programmed I/O reads and writes to the bank.
// Assumes a single caller; each access aligns itself to a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_pio_model
  import disk_regs_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Programmed I/O
  input wire disk_regs_pkg::word_t rdata_i,
  output disk_regs_pkg::pio_req_s req_o
);
  initial req_o = '{wr: 1'b0, rd: 1'b0, sel: REG_NONE, wdata: 12'h000};

  // Released data lines show the inverse, so stale data is never mistaken for a real write
  task automatic access(input logic wr, input reg_sel_e sel, input word_t wdata, output word_t rdata);
    @(posedge clk_i);
    #1;
    req_o = '{wr: wr, rd: !wr, sel: sel, wdata: wdata};
    @(posedge clk_i);
    #1;
    rdata = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, sel: REG_NONE, wdata: ~wdata};
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the disk controller register bank.
// Assumes the host model drives programmed I/O; this module drives engine and drive events.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import disk_regs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic xstart = 1'b0, xread = 1'b0, xend = 1'b0, fmt = 1'b0, wp = 1'b0, fsw = 1'b0, sreq = 1'b0;
  logic [3:0] present = 4'hf, ready = 4'hf, fixed = 4'h0, moving = 4'h0;
  logic [3:0] sd = 4'h0, sh = 4'h0, si = 4'h0, go_seen;
  port_t sport = 2'h0;
  xfer_err_s xerr = '0;
  pio_req_s req;
  word_t rdata;
  logic fgrant, abort, intr;
  logic [2:0] ext;
  port_t usel;
  logic [3:0] sgo, rest;
  int error_cnt = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  host_pio_model host_pio_model_i (.clk_i(clk), .rdata_i(rdata), .req_o(req));

  disk_ctrl_regs disk_ctrl_regs_i (
    .CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .PIO_REQ_I(req), .PIO_RDATA_O(rdata),
    .XFER_START_I(xstart), .XFER_READ_I(xread), .XFER_END_I(xend), .XFER_ERR_I(xerr),
    .FMT_REQ_I(fmt), .WP_HIT_I(wp), .FMT_SWITCH_I(fsw), .FMT_GRANT_O(fgrant), .ABORT_O(abort),
    .DMA_EXT_O(ext), .UNIT_SEL_O(usel), .INT_REQ_O(intr), .DISK_PRESENT_I(present),
    .DRIVE_READY_I(ready), .FIXED_HEAD_I(fixed), .HEAD_MOVING_I(moving), .SEEK_REQ_I(sreq),
    .SEEK_PORT_I(sport), .SEEK_DONE_I(sd), .SEEK_HW_ERR_I(sh), .SEEK_INCOMPLETE_I(si),
    .SEEK_GO_O(sgo), .RESTORE_O(rest)
  );

  task automatic summarize;
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input word_t exp, input word_t got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input reg_sel_e s, input word_t d);
    word_t t;
    host_pio_model_i.access(1'b1, s, d, t);
  endtask

  task automatic rd_chk(input string what, input reg_sel_e s, input word_t mask, input word_t exp);
    word_t t;
    host_pio_model_i.access(1'b0, s, 12'h000, t);
    chk(what, exp, t & mask);
  endtask

  // One-cycle event pulses; registered answers are settled when this returns
  task automatic strobe(input logic [4:0] m, input xfer_err_s e = '0, input logic [3:0] d = 4'h0,
                        input logic [3:0] h = 4'h0, input logic [3:0] i = 4'h0);
    @(posedge clk);
    #1;
    {xstart, xend, fmt, wp, sreq} = m;
    xerr = e;
    sd = d;
    sh = h;
    si = i;
    #1;
    go_seen = sgo;
    @(posedge clk);
    #1;
    {xstart, xend, fmt, wp, sreq} = 5'h00;
    xerr = '0;
    sd = 4'h0;
    sh = 4'h0;
    si = 4'h0;
  endtask

  task automatic t_reset;
    rd_chk("ctl reset", REG_CONTROL, 12'hfff, 12'h000);
    rd_chk("seek reset", REG_SEEK_STATUS, 12'hfff, 12'h000);
    wr(REG_STATUS, 12'hfff);
    rd_chk("status codes", REG_STATUS, 12'hfff, 12'h07f);
    wr(REG_STATUS, 12'h000);
    rd_chk("status clear", REG_STATUS, 12'hfff, 12'h000);
  endtask

  task automatic t_control;
    wr(REG_CONTROL, 12'hfff);
    rd_chk("ctl", REG_CONTROL, 12'hfff, 12'h9e7);
    chk("dma ext", 12'h007, {9'h0, ext});
    chk("irq on", 12'h001, {11'h0, intr});
    wr(REG_CONTROL, 12'h020);
    chk("irq off", 12'h000, {11'h0, intr});
  endtask

  task automatic t_transfer;
    wr(REG_CONTROL, 12'h0a0);
    xread = 1'b1;
    strobe(5'b10000);
    rd_chk("xfer rd busy", REG_CONTROL, 12'hfff, 12'h6a0);
    rd_chk("status busy", REG_STATUS, 12'hc00, 12'h400);
    chk("unit sel", 12'h001, {10'h0, usel});
    strobe(5'b01000);
    rd_chk("xfer done", REG_CONTROL, 12'hdff, 12'h8a0);
    chk("irq done", 12'h001, {11'h0, intr});
    xread = 1'b0;
    strobe(5'b10000);
    rd_chk("xfer wr busy", REG_CONTROL, 12'hfff, 12'h4a0);
    strobe(5'b01000);
  endtask

  // Every code of every error group aborts a busy transfer and is recorded
  task automatic t_errors;
    for (int g = 0; g < 3; g++) begin
      for (int c = 1; c < 4; c++) begin
        strobe(5'b10000);
        strobe(5'b00000, '{valid: 1'b1, group: g[1:0], code: c[1:0]});
        chk("abort", 12'h001, {11'h0, abort});
        rd_chk("err code", REG_STATUS, 12'hfff, 12'h801 | (word_t'(c) << (1 + 2 * g)));
        wr(REG_STATUS, 12'h000);
      end
    end
  endtask

  task automatic t_format;
    wr(REG_CONTROL, 12'h000);
    strobe(5'b00100);
    chk("fmt off", 12'h000, {11'h0, fgrant});
    rd_chk("fmt err", REG_STATUS, 12'h07f, 12'h003);
    wr(REG_STATUS, 12'h000);
    wr(REG_CONTROL, 12'h040);
    strobe(5'b00100);
    chk("fmt on", 12'h001, {11'h0, fgrant});
    fixed = 4'hf;
    strobe(5'b00100);
    chk("fmt fixed", 12'h000, {11'h0, fgrant});
    rd_chk("fmt fixed err", REG_STATUS, 12'h07f, 12'h003);
    wr(REG_STATUS, 12'h000);
    fixed = 4'h0;
    fsw = 1'b1;
    strobe(5'b00010);
    rd_chk("lockout override", REG_STATUS, 12'h07f, 12'h000);
    fsw = 1'b0;
    strobe(5'b00010);
    rd_chk("lockout", REG_STATUS, 12'h07f, 12'h021);
    wr(REG_STATUS, 12'h000);
  endtask

  task automatic t_seek;
    wr(REG_CONTROL, 12'h000);
    sport = 2'h2;
    strobe(5'b00001);
    chk("seek go", 12'h004, {8'h0, go_seen});
    strobe(5'b00000, '0, 4'h4, 4'h4, 4'h4);
    chk("restore", 12'h004, {8'h0, rest});
    rd_chk("seek hw err", REG_SEEK_STATUS, 12'hfff, 12'h008);
    rd_chk("seek done", REG_CONTROL, 12'h800, 12'h800);
    strobe(5'b00001);
    rd_chk("seek clear", REG_SEEK_STATUS, 12'hfff, 12'h000);
    moving = 4'h4;
    rd_chk("seek moving", REG_SEEK_STATUS, 12'hfff, 12'h020);
    strobe(5'b00001);
    chk("seek refused", 12'h000, {8'h0, go_seen});
    rd_chk("seek busy err", REG_SEEK_STATUS, 12'hfff, 12'h030);
    present = 4'h7;
    wr(REG_SEEK_STATUS, 12'h000);
    rd_chk("seek absent", REG_SEEK_STATUS, 12'hfff, 12'h037);
    rd_chk("unmapped", REG_NONE, 12'hfff, 12'h000);
  endtask

  // Start on an absent port: select error and done, never busy
  task automatic t_select;
    wr(REG_CONTROL, 12'h180);
    strobe(5'b10000);
    rd_chk("select err", REG_STATUS, 12'hfff, 12'h805);
    wr(REG_STATUS, 12'h000);
  endtask

  // Enable low freezes a host write; a mid-run reset clears the control word
  task automatic t_freeze;
    ce = 1'b0;
    wr(REG_CONTROL, 12'h007);
    ce = 1'b1;
    rd_chk("ce freeze", REG_CONTROL, 12'h07f, 12'h000);
    wr(REG_CONTROL, 12'hfff);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("irq reset", 12'h000, {11'h0, intr});
    rd_chk("ctl rerun", REG_CONTROL, 12'hfff, 12'h000);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_control();
    t_transfer();
    t_errors();
    t_format();
    t_seek();
    t_select();
    t_freeze();
    summarize();
  end

  // Cuts a hang short well above the cycle count of a normal run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
